/* core/lsb_pkg.sv */
package lsb_pkg;

	// =====================================================================
	// clocking
	localparam int unsigned CLK_HZ       = 40_000_000;
	localparam int unsigned CLK_MHZ      = 40;
	localparam int unsigned XTAL_HZ      = 15_000_000;
	localparam int unsigned CPU_HZ       = XTAL_HZ / 3;
	localparam int unsigned DMA_HZ       = XTAL_HZ / 2;
	localparam int unsigned SIO_HZ       = XTAL_HZ / 4;
	localparam int unsigned NCO_W        = 27;
	localparam logic [NCO_W-1:0] NCO_MOD = NCO_W'(CLK_HZ);
	// phase steps: twice the output rate, one toggle per wrap
	localparam logic [NCO_W-1:0] NCO_INC [3] = '{
		NCO_W'(2 * CPU_HZ), NCO_W'(2 * DMA_HZ), NCO_W'(2 * SIO_HZ)};
	localparam logic [NCO_W-1:0] NCO_RST   = 27'h0000000;

	// =====================================================================
	// processor reset stretch, in processor clock cycles
	localparam logic [2:0] CPU_RST_CYC = 3'h4;

	// =====================================================================
	// bus timeout one-shot
	localparam int unsigned TIMEOUT_NS  = 10_000;
	localparam int unsigned TIMEOUT_CYC =
		(TIMEOUT_NS * CLK_MHZ + 999) / 1000;

	// =====================================================================
	// local address map, quarter code is addr[19:18]
	localparam logic [1:0] Q_LOCAL_RAM = 2'h0;  // 00000..3ffff
	localparam logic [1:0] Q_SYS_IO    = 2'h1;  // 40000..7ffff
	localparam logic [1:0] Q_SYS_MEM   = 2'h2;  // 80000..bffff
	localparam logic [1:0] Q_LOCAL_ROM = 2'h3;  // c0000..fffff
	// register window inside the low quarter, addr[17:15]
	localparam logic [2:0] REG_AREA    = 3'h1;
	// dma controller inside the register window, addr[7:3]
	localparam logic [4:0] DMA_AREA    = 5'h11;
	// bank used for the system i/o page
	localparam logic [5:0] IO_PAGE_BANK = 6'h3f;
	localparam logic [7:0] TIMEOUT_DATA = 8'hff;

	// =====================================================================
	// bridge sequencer
	typedef enum logic [1:0] {
		LSB_IDLE = 2'b00,
		LSB_REQ  = 2'b01,
		LSB_XFER = 2'b10,
		LSB_HOLD = 2'b11
	} lsb_state_e;

endpackage : lsb_pkg

/* core/lsb_bridge.sv */
// Contract
// RQ1 - local 00000..3ffff goes to on-board ram and control registers
// RQ2 - local 40000..7ffff reaches the system bus i/o page
// RQ3 - local 80000..bffff reaches system memory through the bank register
// RQ4 - local c0000..fffff selects on-board prom and rom
// RQ5 - registers sit in memory space; only diagnostics decode in i/o space
// RQ6 - partial register decode, low bits ignored except for the dma block
// RQ7 - six-bit bank register picks one 64k bank of the 22-bit space
// RQ8 - system address is bank bits above local address bits 15..0
// RQ9 - control bit 7 set gives byte transfers, clear gives word transfers
// RQ10 - a system access raises local wait and requests bus mastership
// RQ11 - after grant drive read or write strobe low, hold until reply
// RQ12 - target replies after taking write data or driving read data
// RQ13 - on reply finish the bus cycle and release local wait
// RQ14 - no reply before the one-shot expires sets bit 6, ends strobe
// RQ15 - reset input high gives processor reset for four processor clocks
// RQ16 - 5, 7.5 and 3.75 mhz clocks derived from a 15 mhz crystal; here made by phase accumulators from the 40 mhz system clock
// RQ17 - byte mode runs one bus cycle; byte writes drive byte_write_select
// RQ18 - word mode even write only latches; odd write sends whole word
// RQ19 - word mode even read fetches word; odd read comes from latch
// RQ20 - firmware polls the timeout flag, handles it and clears it
`timescale 1ns/1ps

module lsb_bridge
	import lsb_pkg::*;
#(
	parameter int unsigned TO_CYC = TIMEOUT_CYC
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        rst_in,
	// local processor bus (pins)
	input  wire logic [19:0] loc_addr,
	input  wire logic [7:0]  loc_wdata,
	input  wire logic        loc_rd_n,
	input  wire logic        loc_wr_n,
	input  wire logic        loc_io,
	output logic      [7:0]  loc_rdata_ff,
	output logic             wait_req_ff,
	// local selects
	output logic             ram_sel_ff,
	output logic             ctl_sel_ff,
	output logic             dma_sel_ff,
	output logic      [2:0]  dma_idx_ff,
	output logic             rom_sel_ff,
	output logic             diag_sel_ff,
	// control bits
	input  wire logic [5:0]  bank_ext,
	input  wire logic        byte_mode,
	input  wire logic        timeout_clr,
	output logic             timeout_err_ff,
	// system bus (pins)
	input  wire logic        sys_grant_n,
	input  wire logic        sys_reply_n,
	input  wire logic [15:0] sys_rdata,
	output logic             sys_req_ff,
	output logic      [21:0] sys_addr_ff,
	output logic             sys_io_page_ff,
	output logic      [15:0] sys_wdata_ff,
	output logic             sys_oe_ff,
	output logic             sys_din_n_ff,
	output logic             sys_dout_n_ff,
	output logic             byte_write_select_ff,
	// generated clocks and processor reset
	output logic      [2:0]  clk_out_ff,
	output logic             cpu_reset_ff
);

	// =====================================================================
	// elaboration checks
	if (TO_CYC < 1 || TO_CYC > 65535) begin : g_bad_to
		$error("lsb_bridge: TO_CYC out of range");
	end

	// =====================================================================
	// pin synchronisers, two stages before any logic looks
	logic [19:0] addr_s1_ff, addr_s2_ff;
	logic [7:0]  wdat_s1_ff, wdat_s2_ff;
	logic [15:0] rdat_s1_ff, rdat_s2_ff;
	logic [5:0]  ctl_s1_ff,  ctl_s2_ff;

	// one always for all pins; stage 1 only feeds stage 2
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			addr_s1_ff <= 20'h00000;
			addr_s2_ff <= 20'h00000;
			wdat_s1_ff <= 8'h00;
			wdat_s2_ff <= 8'h00;
			rdat_s1_ff <= 16'h0000;
			rdat_s2_ff <= 16'h0000;
			ctl_s1_ff  <= 6'h1b;
			ctl_s2_ff  <= 6'h1b;
		end else begin
			addr_s1_ff <= loc_addr;
			addr_s2_ff <= addr_s1_ff;
			wdat_s1_ff <= loc_wdata;
			wdat_s2_ff <= wdat_s1_ff;
			rdat_s1_ff <= sys_rdata;
			rdat_s2_ff <= rdat_s1_ff;
			ctl_s1_ff  <= {rst_in, sys_reply_n, sys_grant_n,
				loc_io, loc_wr_n, loc_rd_n};
			ctl_s2_ff  <= ctl_s1_ff;
		end
	end

	logic rd_act, wr_act, io_act, grant, reply, rst_req;
	assign rd_act  = ~ctl_s2_ff[0];
	assign wr_act  = ~ctl_s2_ff[1];
	assign io_act  = ctl_s2_ff[2];
	assign grant   = ~ctl_s2_ff[3];
	assign reply   = ~ctl_s2_ff[4];
	assign rst_req = ctl_s2_ff[5];

	// =====================================================================
	// local decode
	function automatic logic [1:0] quarter(input logic [19:0] a);
		quarter = a[19:18];
	endfunction : quarter

	logic [1:0] q_cur;
	logic       is_sys;
	assign q_cur  = quarter(addr_s2_ff);
	assign is_sys = (q_cur == Q_SYS_IO) || (q_cur == Q_SYS_MEM);

	// selects follow the live strobe; registered so outputs are clean
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ram_sel_ff  <= 1'b0;
			ctl_sel_ff  <= 1'b0;
			dma_sel_ff  <= 1'b0;
			dma_idx_ff  <= 3'h0;
			rom_sel_ff  <= 1'b0;
			diag_sel_ff <= 1'b0;
		end else begin
			ram_sel_ff  <= (rd_act | wr_act) & ~io_act
				& (q_cur == Q_LOCAL_RAM)
				& (addr_s2_ff[17:15] != REG_AREA);  // see RQ1
			// low bits ignored, except the dma block's index
			ctl_sel_ff  <= (rd_act | wr_act) & ~io_act
				& (q_cur == Q_LOCAL_RAM)
				& (addr_s2_ff[17:15] == REG_AREA)
				& (addr_s2_ff[7:3] != DMA_AREA);  // see RQ5 see RQ6
			dma_sel_ff  <= (rd_act | wr_act) & ~io_act
				& (q_cur == Q_LOCAL_RAM)
				& (addr_s2_ff[17:15] == REG_AREA)
				& (addr_s2_ff[7:3] == DMA_AREA);  // see RQ6
			dma_idx_ff  <= addr_s2_ff[2:0];  // see RQ6
			rom_sel_ff  <= (rd_act | wr_act) & ~io_act
				& (q_cur == Q_LOCAL_ROM);  // see RQ4
			diag_sel_ff <= (rd_act | wr_act) & io_act;  // see RQ5
		end
	end

	// =====================================================================
	// bridge sequencer
	lsb_state_e  state_ff;
	logic        act_prev_ff;
	logic        is_wr_ff;
	logic        odd_ff;
	logic        byte_ff;
	logic [7:0]  wr_lat_lo_ff;
	logic [7:0]  rd_lat_hi_ff;
	logic [15:0] timer_ff;
	logic        start, busy, expired;

	assign start   = (rd_act | wr_act) & ~act_prev_ff & ~io_act;
	assign busy    = (state_ff == LSB_REQ) || (state_ff == LSB_XFER);
	// a reply in the last cycle still counts as a reply
	assign expired = busy && (timer_ff == 16'h0000)
		&& !((state_ff == LSB_XFER) && reply);

	// edge memory for the local strobe
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			act_prev_ff <= 1'b0;
		else
			act_prev_ff <= rd_act | wr_act;
	end

	// one-shot: loaded on request, runs through grant and strobe
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			timer_ff <= 16'h0000;
		else if (state_ff == LSB_IDLE)
			timer_ff <= 16'(TO_CYC - 1);
		else if (busy && timer_ff != 16'h0000)
			timer_ff <= timer_ff - 16'h0001;
	end

	// sequencer and system bus drive; wait is raised three clocks after
	// the local strobe because of the pin synchroniser
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_ff             <= LSB_IDLE;
			wait_req_ff          <= 1'b0;
			sys_req_ff           <= 1'b0;
			sys_addr_ff          <= 22'h000000;
			sys_io_page_ff       <= 1'b0;
			sys_wdata_ff         <= 16'h0000;
			sys_oe_ff            <= 1'b0;
			sys_din_n_ff         <= 1'b1;
			sys_dout_n_ff        <= 1'b1;
			byte_write_select_ff <= 1'b0;
			loc_rdata_ff         <= 8'h00;
			is_wr_ff             <= 1'b0;
			odd_ff               <= 1'b0;
			byte_ff              <= 1'b0;
			wr_lat_lo_ff         <= 8'h00;
			rd_lat_hi_ff         <= 8'h00;
		end else begin
			case (state_ff)
			LSB_IDLE: begin
				if (start && is_sys) begin
					if (!byte_mode && wr_act && !addr_s2_ff[0]) begin
						wr_lat_lo_ff <= wdat_s2_ff;  // see RQ18
					end else if (!byte_mode && rd_act && addr_s2_ff[0]) begin
						loc_rdata_ff <= rd_lat_hi_ff;  // see RQ19
					end else begin
						wait_req_ff <= 1'b1;  // see RQ10
						sys_req_ff  <= 1'b1;  // see RQ10
						is_wr_ff    <= wr_act;
						odd_ff      <= addr_s2_ff[0];
						byte_ff     <= byte_mode;  // see RQ9
						sys_io_page_ff <= (q_cur == Q_SYS_IO);  // see RQ2
						// word cycles always use the even address
						sys_addr_ff <= {
							(q_cur == Q_SYS_IO) ? IO_PAGE_BANK : bank_ext,
							addr_s2_ff[15:1],
							addr_s2_ff[0] & byte_mode};  // see RQ3 see RQ7 see RQ8
						sys_wdata_ff <= byte_mode
							? {wdat_s2_ff, wdat_s2_ff}
							: {wdat_s2_ff, wr_lat_lo_ff};  // see RQ18
						state_ff <= LSB_REQ;
					end
				end
			end
			LSB_REQ: begin
				if (expired) begin
					sys_req_ff   <= 1'b0;  // see RQ14
					wait_req_ff  <= 1'b0;
					loc_rdata_ff <= TIMEOUT_DATA;
					state_ff     <= LSB_HOLD;
				end else if (grant) begin
					sys_din_n_ff  <= is_wr_ff;  // see RQ11
					sys_dout_n_ff <= ~is_wr_ff;  // see RQ11
					sys_oe_ff     <= is_wr_ff;
					byte_write_select_ff <= is_wr_ff & byte_ff;  // see RQ17
					state_ff      <= LSB_XFER;
				end
			end
			LSB_XFER: begin
				// strobe stands until the target answers or time runs out
				if (reply || expired) begin  // see RQ12
					sys_din_n_ff  <= 1'b1;  // see RQ13 see RQ14
					sys_dout_n_ff <= 1'b1;
					sys_oe_ff     <= 1'b0;
					sys_req_ff    <= 1'b0;
					byte_write_select_ff <= 1'b0;
					wait_req_ff   <= 1'b0;  // see RQ13
					state_ff      <= LSB_HOLD;
					if (!reply)
						loc_rdata_ff <= TIMEOUT_DATA;
					else if (!is_wr_ff && byte_ff)
						loc_rdata_ff <= odd_ff ? rdat_s2_ff[15:8]
							: rdat_s2_ff[7:0];  // see RQ17
					else if (!is_wr_ff) begin
						loc_rdata_ff <= rdat_s2_ff[7:0];  // see RQ19
						rd_lat_hi_ff <= rdat_s2_ff[15:8];  // see RQ19
					end
				end
			end
			LSB_HOLD: begin
				// let the local cycle close before taking another
				if (!rd_act && !wr_act)
					state_ff <= LSB_IDLE;
			end
			default: state_ff <= LSB_IDLE;
			endcase
		end
	end

	// =====================================================================
	// timeout flag: a new timeout beats a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			timeout_err_ff <= 1'b0;
		else if (expired)
			timeout_err_ff <= 1'b1;  // see RQ14
		else if (timeout_clr)
			timeout_err_ff <= 1'b0;  // see RQ20
	end

	// =====================================================================
	// clock generation: phase accumulators give exact average rates
	// from the system clock; edges jitter by one system period
	logic [NCO_W-1:0] acc_ff [3];
	logic [2:0]       wrap;
	logic [NCO_W-1:0] acc_sum [3];

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			acc_sum[i] = acc_ff[i] + NCO_INC[i];
			wrap[i]    = acc_sum[i] >= NCO_MOD;
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 3; i++) begin
			if (!rst_n) begin
				acc_ff[i]     <= NCO_RST;
				clk_out_ff[i] <= 1'b0;
			end else if (wrap[i]) begin
				acc_ff[i]     <= acc_sum[i] - NCO_MOD;  // see RQ16
				clk_out_ff[i] <= ~clk_out_ff[i];
			end else begin
				acc_ff[i]     <= acc_sum[i];
			end
		end
	end

	// =====================================================================
	// processor reset, counted on processor clock rising edges
	logic [2:0] rst_cnt_ff;
	logic       cpu_rise;
	assign cpu_rise = wrap[0] & ~clk_out_ff[0];

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rst_cnt_ff   <= CPU_RST_CYC;
			cpu_reset_ff <= 1'b1;
		end else begin
			if (rst_req)
				rst_cnt_ff <= CPU_RST_CYC;  // see RQ15
			else if (cpu_rise && rst_cnt_ff != 3'h0)
				rst_cnt_ff <= rst_cnt_ff - 3'h1;
			// changes only on a processor clock edge
			if (cpu_rise)
				cpu_reset_ff <= rst_req || (rst_cnt_ff > 3'h1);  // see RQ15
		end
	end

endmodule : lsb_bridge

/* test/lsb_bridge_sva.sv */
`timescale 1ns/1ps
// ==========================================
// pin checker for the bridge
module lsb_bridge_sva
	import lsb_pkg::*;
#(
	parameter int unsigned TO_CYC = TIMEOUT_CYC
) (
	// clock, reset and control
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        byte_mode,
	input wire logic        timeout_clr,
	input wire logic [5:0]  bank_ext,
	// system bus and status
	input wire logic        sys_grant_n,
	input wire logic        sys_reply_n,
	input wire logic        sys_req_ff,
	input wire logic [21:0] sys_addr_ff,
	input wire logic        sys_io_page_ff,
	input wire logic        sys_din_n_ff,
	input wire logic        sys_dout_n_ff,
	input wire logic        sys_oe_ff,
	input wire logic        byte_write_select_ff,
	input wire logic        wait_req_ff,
	input wire logic        timeout_err_ff
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [9:0] req_cnt_ff;

	// clocks spent in the current request; a stuck strobe grows it
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !sys_req_ff) req_cnt_ff <= 10'h000;
		else req_cnt_ff <= req_cnt_ff + 10'h001;
	end

	// reply seen while a strobe is out, then the bus handed back
	sequence s_reply;
		$fell(sys_reply_n) && !(sys_din_n_ff && sys_dout_n_ff);
	endsequence
	sequence s_done;
		sys_din_n_ff && sys_dout_n_ff && !sys_req_ff && !wait_req_ff;
	endsequence

	a_req_waits: assert property (
		sys_req_ff |-> wait_req_ff) else $error("request without wait");
	a_strobe_granted: assert property (
		$fell(sys_din_n_ff) || $fell(sys_dout_n_ff) |->
		sys_req_ff && !$past(sys_grant_n)) else $error("strobe ungranted");
	a_reply_ends: assert property (
		s_reply |-> ##[1:4] s_done) else $error("reply not finished");
	a_timeout_bound: assert property (
		req_cnt_ff <= TO_CYC + 3) else $error("request outlived timer");
	a_flag_cause: assert property (
		$rose(timeout_err_ff) |-> $past(sys_req_ff))
		else $error("flag without access");
	a_flag_sticky: assert property (
		timeout_err_ff && !timeout_clr |=> timeout_err_ff)
		else $error("flag lost");
	// data lanes are driven exactly while the write strobe is out
	a_oe_write: assert property (
		sys_oe_ff == !sys_dout_n_ff) else $error("data enable wrong");
	a_byte_select: assert property (
		byte_write_select_ff == (!sys_dout_n_ff && byte_mode))
		else $error("byte select wrong");
	a_bank_addr: assert property (
		sys_req_ff && !sys_io_page_ff |-> sys_addr_ff[21:16] == bank_ext)
		else $error("bank bits wrong");
	a_io_bank: assert property (
		sys_req_ff && sys_io_page_ff |->
		sys_addr_ff[21:16] == IO_PAGE_BANK) else $error("io bank wrong");
endmodule : lsb_bridge_sva

/* test/lsb_sys_model.sv */
`timescale 1ns/1ps
// ==========================================
// system bus target: grant, reply, lanes
module lsb_sys_model (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// bridge side
	input  wire logic        sys_req_ff,
	input  wire logic        sys_din_n_ff,
	input  wire logic        sys_dout_n_ff,
	input  wire logic [21:0] sys_addr_ff,
	input  wire logic [15:0] sys_wdata_ff,
	output logic             sys_grant_n,
	output logic             sys_reply_n,
	output logic      [15:0] sys_rdata,
	// bench control and record
	input  wire logic        mute,
	input  wire logic [3:0]  lag,
	output logic      [15:0] wr_word,
	output logic      [21:0] wr_addr,
	output logic      [7:0]  n_cyc
);
	logic [3:0] cnt_ff;

	// grant follows the request one clock later and drops one clock after it
	always_ff @(posedge clk_sys) begin
		sys_grant_n <= !rst_n || !sys_req_ff;
	end

	// reply lag clocks into a strobe; lanes not driven keep changing
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt_ff      <= 4'h0;
			sys_reply_n <= 1'b1;
			sys_rdata   <= 16'h0000;
			n_cyc       <= 8'h00;
		end else if (sys_din_n_ff && sys_dout_n_ff) begin
			cnt_ff      <= 4'h0;
			sys_reply_n <= 1'b1;
			sys_rdata   <= ~sys_rdata;
		end else if (cnt_ff != 4'hf) begin
			cnt_ff <= cnt_ff + 4'h1;
			if (cnt_ff == lag && !mute) begin
				sys_reply_n <= 1'b0;
				sys_rdata   <= {~sys_addr_ff[7:0], sys_addr_ff[7:0]};
				n_cyc       <= n_cyc + 8'h01;
				wr_word     <= sys_dout_n_ff ? wr_word : sys_wdata_ff;
				wr_addr     <= sys_dout_n_ff ? wr_addr : sys_addr_ff;
			end else if (sys_reply_n) begin
				sys_rdata <= ~sys_rdata;
			end
		end
	end
endmodule : lsb_sys_model

/* test/lsb_bridge_tb.sv */
`timescale 1ns/1ps
// ==========================================
// bench for the bridge
module lsb_bridge_tb
	import lsb_pkg::*;
;
	localparam int unsigned TO_CYC = 20;
	logic        clk_sys, rst_n, rst_in, loc_rd_n, loc_wr_n, loc_io, mute;
	logic        byte_mode, timeout_clr, sys_grant_n, sys_reply_n, wait_seen;
	logic        wait_req_ff, ram_sel_ff, ctl_sel_ff, dma_sel_ff, rom_sel_ff;
	logic        diag_sel_ff, timeout_err_ff, sys_req_ff, sys_io_page_ff;
	logic        sys_oe_ff, sys_din_n_ff, sys_dout_n_ff, cpu_reset_ff;
	logic        byte_write_select_ff;
	logic [2:0]  clk_out_ff, dma_idx_ff;
	logic [3:0]  lag;
	logic [4:0]  sel_seen;
	logic [5:0]  bank_ext;
	logic [7:0]  loc_wdata, loc_rdata_ff, n_cyc;
	logic [15:0] sys_rdata, sys_wdata_ff, wr_word;
	logic [19:0] loc_addr;
	logic [21:0] sys_addr_ff, wr_addr;
	int          miscompares, check_count, cyc;

	lsb_bridge #(.TO_CYC(TO_CYC)) lsb_bridge_inst (.*);
	lsb_sys_model lsb_sys_model_inst (.*);

	// 40 mhz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// hang guard, far above the roughly 1200 clocks the run needs
	initial begin
		cyc = 0;
		forever begin
			@(posedge clk_sys);
			cyc++;
			if (cyc == 20000) begin
				miscompares++;
				complete_run();
			end
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	task automatic chk(input string nm, input logic [21:0] e,
		input logic [21:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	// one local cycle; the strobe stays until the wait is dropped
	task automatic loc(input logic [19:0] a, input logic wr,
		input logic [7:0] d, input logic io);
		loc_addr  = a;
		loc_wdata = d;
		loc_io    = io;
		loc_wr_n  = !wr;
		loc_rd_n  = wr;
		step(5);
		sel_seen  = {ram_sel_ff, ctl_sel_ff, dma_sel_ff, rom_sel_ff,
			diag_sel_ff};
		wait_seen = wait_req_ff;
		for (int n = 0; n < 100 && wait_req_ff !== 1'b0; n++) step(1);
		chk("wait_end", 1'b0, wait_req_ff);
		loc_rd_n = 1'b1;
		loc_wr_n = 1'b1;
		step(4);
	endtask : loc

	// processor reset stretch and derived clock rates
	task automatic sc_clocks();
		logic [2:0] pv;
		int c [3] = '{0, 0, 0};
		int e [3] = '{100, 150, 75};
		chk("cpu_rst", 1'b1, cpu_reset_ff);
		step(80);
		chk("cpu_rst", 1'b0, cpu_reset_ff);
		rst_in = 1'b1;
		step(10);
		chk("cpu_rst", 1'b1, cpu_reset_ff);
		rst_in = 1'b0;
		step(12);
		chk("cpu_rst", 1'b1, cpu_reset_ff);
		step(60);
		chk("cpu_rst", 1'b0, cpu_reset_ff);
		for (int i = 0; i < 800; i++) begin
			pv = clk_out_ff;
			step(1);
			for (int k = 0; k < 3; k++) c[k] += int'(clk_out_ff[k] & ~pv[k]);
		end
		for (int k = 0; k < 3; k++) begin
			chk("clk_rate", 1'b1, c[k] >= e[k] - 1 && c[k] <= e[k] + 1);
		end
		$display("test clocks done");
	endtask : sc_clocks

	// on-board quarters, partial register decode and i/o space
	task automatic sc_decode();
		logic [19:0] ad [6] = '{20'h30123, 20'h0c040, 20'h0fff6,
			20'h0908d, 20'hc7f3e, 20'h00042};
		logic [4:0] ex [6] = '{5'h10, 5'h08, 5'h08, 5'h04, 5'h02, 5'h01};
		for (int i = 0; i < 6; i++) begin
			loc(ad[i], 1'b0, 8'h00, i == 5);
			chk("select", ex[i], sel_seen);
			chk("no_wait", 1'b0, wait_seen);
			chk("dma_idx", ad[i][2:0], dma_idx_ff);
		end
		$display("test decode done");
	endtask : sc_decode

	// byte mode with a slow target, memory and i/o page
	task automatic sc_byte();
		byte_mode = 1'b1;
		bank_ext  = 6'h2a;
		lag       = 4'h8;
		loc(20'h81235, 1'b1, 8'h5c, 1'b0);
		chk("wait", 1'b1, wait_seen);
		chk("wr_addr", {6'h2a, 16'h1235}, wr_addr);
		chk("wr_word", 16'h5c5c, wr_word);
		loc(20'h81235, 1'b0, 8'h00, 1'b0);
		chk("rdata", 8'hca, loc_rdata_ff);
		loc(20'h45678, 1'b1, 8'h9e, 1'b0);
		chk("io_addr", {IO_PAGE_BANK, 16'h5678}, wr_addr);
		$display("test byte done");
	endtask : sc_byte

	// word mode pairs, back to back, prompt target
	task automatic sc_word();
		logic [7:0] nb;
		byte_mode = 1'b0;
		bank_ext  = 6'h15;
		lag       = 4'h0;
		nb        = n_cyc;
		loc(20'h80010, 1'b1, 8'h11, 1'b0);
		chk("latch_wr", {1'b0, nb}, {wait_seen, n_cyc});
		loc(20'h80011, 1'b1, 8'h22, 1'b0);
		chk("wr_word", 16'h2211, wr_word);
		chk("wr_addr", {6'h15, 16'h0010}, wr_addr);
		loc(20'h80020, 1'b0, 8'h00, 1'b0);
		chk("rd_low", 8'h20, loc_rdata_ff);
		loc(20'h80021, 1'b0, 8'h00, 1'b0);
		chk("rd_high", {1'b0, 8'hdf}, {wait_seen, loc_rdata_ff});
		chk("cycles", nb + 8'h02, n_cyc);
		$display("test word done");
	endtask : sc_word

	// silent target, then firmware clears the flag
	task automatic sc_timeout();
		mute = 1'b1;
		loc(20'h80002, 1'b0, 8'h00, 1'b0);
		chk("timeout", 1'b1, timeout_err_ff);
		chk("to_data", TIMEOUT_DATA, loc_rdata_ff);
		mute = 1'b0;
		step(20);
		chk("sticky", 1'b1, timeout_err_ff);
		timeout_clr = 1'b1;
		step(1);
		timeout_clr = 1'b0;
		step(1);
		chk("cleared", 1'b0, timeout_err_ff);
		$display("test timeout done");
	endtask : sc_timeout

	initial begin
		rst_n = 1'b0;
		rst_in = 1'b0;
		loc_rd_n = 1'b1;
		loc_wr_n = 1'b1;
		loc_io = 1'b0;
		loc_addr = 20'h00000;
		loc_wdata = 8'h00;
		bank_ext = 6'h00;
		byte_mode = 1'b1;
		timeout_clr = 1'b0;
		mute = 1'b0;
		lag = 4'h0;
		miscompares = 0;
		check_count = 0;
		step(12);
		rst_n = 1'b1;
		sc_clocks();
		sc_decode();
		sc_byte();
		sc_word();
		sc_timeout();
		complete_run();
	end
endmodule : lsb_bridge_tb

bind lsb_bridge lsb_bridge_sva #(.TO_CYC(TO_CYC)) lsb_bridge_sva_inst (.*);
